// ### core/ccc_pkg.sv
// Constants, register map and state types of the charge cycle controller.
// Assumes a 100 MHz clock and a 32-bit AHB-Lite register bus.
package ccc_pkg;
  // Register byte offsets
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_CURR = 4'h4;
  localparam logic [3:0] A_VREG = 4'h8;
  localparam logic [3:0] A_STAT = 4'hc;
  // Control register bit positions
  localparam int B_HIZ = 0;
  localparam int B_CFG = 1;
  localparam int B_SRST = 3;
  localparam int B_TERM = 4;
  localparam int B_EARLY = 5;
  localparam int B_TMR = 6;
  localparam int B_DUR = 7;
  localparam int B_HALF = 9;
  localparam int B_RECH = 10;
  localparam int B_WARM = 11;
  localparam int B_COOL = 12;
  localparam int B_RED = 13;
  localparam int B_FOFF = 14;
  localparam int B_HOST = 15;
  // Current and voltage register fields
  localparam int F_FAST = 0;
  localparam int F_PRE = 6;
  localparam int F_VREG = 0;
  localparam int F_COMPR = 6;
  localparam int F_CLAMP = 9;
  // Reset values: 4208 mV, 2048 mA, 256 mA, 8 h timer
  localparam logic [15:0] CTRL_RST = 16'h02d2;
  localparam logic [9:0] CURR_RST = 10'h058;
  localparam logic [11:0] VREG_RST = 12'h02c;
  // Field codes
  localparam logic [1:0] CFG_OFF = 2'h0;
  localparam logic [1:0] CFG_CHG = 2'h1;
  localparam logic [1:0] PH_DIS = 2'h0;
  localparam logic [1:0] PH_PRE = 2'h1;
  localparam logic [1:0] PH_FAST = 2'h2;
  localparam logic [1:0] PH_DONE = 2'h3;
  localparam logic [1:0] FLT_END = 2'h3;
  // Analog set points in mA and mV
  localparam int MA_TRICKLE = 100;
  localparam int PRE_BASE_MA = 128;
  localparam int PRE_STEP_MA = 128;
  localparam int FAST_BASE_MA = 512;
  localparam int FAST_STEP_MA = 64;
  localparam int REDUCE_DIV = 5;
  localparam int VREG_BASE_MV = 3504;
  localparam int VREG_STEP_MV = 16;
  localparam int WARM_HI_MV = 4200;
  localparam int WARM_LO_MV = 4050;
  localparam int COMP_R_MOHM = 20;
  localparam int COMP_DIV = 1000;
  localparam int CLAMP_STEP_MV = 32;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int SEC_CYC = CLK_MHZ * 1000000;
  localparam int ALERT_US = 256;
  localparam int ALERT_CYC = ALERT_US * CLK_MHZ;
  localparam int BLINK_HZ = 1;
  localparam int BLINK_CYC = SEC_CYC / (2 * BLINK_HZ);
  localparam logic [16:0] T_1H = 17'(1 * 3600);
  localparam logic [16:0] T_5H = 17'(5 * 3600);
  localparam logic [16:0] T_8H = 17'(8 * 3600);
  localparam logic [16:0] T_12H = 17'(12 * 3600);
  localparam logic [16:0] T_20H = 17'(20 * 3600);
  localparam logic [16:0] T_USB = 17'(45 * 60);

  typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_FAST, ST_DONE, ST_SUSP} ccc_state_e;

  typedef struct packed {
    logic [16:0] cnt;
    logic skip;
    logic done;
    logic exp;
  } ccc_tmr_s;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [9:0] curr;
    logic [11:0] vreg;
    ccc_state_e st;
    logic [1:0] fault;
    logic tfault;
    logic ce_prev;
    logic ce_low;
    logic restart;
    logic dph;
    logic dwr;
    logic dmap;
    logic [3:0] dadr;
    logic [31:0] hrdata;
    logic hrdyo;
    logic hresp;
    logic [26:0] pre;
    logic tick;
    logic [15:0] acnt;
    logic alert;
    logic [25:0] bcnt;
    logic blink;
    logic [1:0] phase;
    logic [12:0] iset;
    logic [12:0] vreg_mv;
    logic stat;
    logic stat_oe;
    logic bsw;
    logic conv;
  } ccc_core_s;
endpackage

// ### core/ccc_timer.sv
// Second-based up-counter to a limit for the safety and USB charge timers.
// Assumes a one-cycle tick each second and a level run enable.
`timescale 1ns/1ps
`default_nettype none
module ccc_timer (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic half_i,
  input wire logic run_i,
  input wire logic restart_i,
  input wire logic [16:0] limit_i,
  output logic expire_o
);
  import ccc_pkg::*;

  ccc_tmr_s q;
  ccc_tmr_s next_q;

  // Count seconds; in half mode only every second tick counts
  always_comb begin
    next_q = q;
    next_q.exp = 1'b0;
    if (restart_i) begin
      next_q.cnt = '0;
      next_q.skip = 1'b0;
      next_q.done = 1'b0;
    end else if (run_i && tick_i && !q.done) begin
      next_q.skip = half_i & ~q.skip;
      if (!half_i || q.skip) begin
        next_q.cnt = q.cnt + 17'h1;
        // Compare with >= so a shortened limit still ends the run
        if (next_q.cnt >= limit_i) begin
          next_q.done = 1'b1;
          next_q.exp = 1'b1;
        end
      end
    end
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign expire_o = q.exp;

  // Half rate: a skipped tick must leave the count where it was
  a_half_skip: assert property (@(posedge clock_i) disable iff (rst_i)
    (run_i && tick_i && half_i && !q.skip && !q.done && !restart_i) |=> (q.cnt == $past(q.cnt)))
    else $error("half rate timer counted a skipped tick");
endmodule // ccc_timer
`default_nettype wire

// ### core/ccc_core.sv
// Charge cycle controller: phase sequencing, timers, set points, status.
// Assumes AHB-Lite single word transfers and synchronous comparator inputs.
// Functional notes
// - Start needs converter, enable, no faults, switch
// - Low current above recharge level ends cycle
// - Discharge below recharge level restarts cycle
// - Phase field: disabled, pre, fast, done
// - Completed cycle raises host alert pulse
// - Indicator low charging, high idle, blinking fault
// - Power-on defaults: 4.208 V, 2.048 A, 8 h
// - Current from battery voltage: trickle, pre, fast
// - Regulation suppresses termination, halves timer rate
// - Regulation target plus min(compensation, clamp)
// - Start only inside thermistor window, else suspend
// - Warm zone voltage cap, cool zone 20%
// - After done switch off, converter keeps running
// - Termination sets fault 11, alert; bit disables
// - Early-done raises indicator below 800 mA
// - Default mode: 5 h, expiry sets input-suspend
// - Host mode: duration field, expiry clears suspend
// - 1 h when battery low; expiry fault, alert
// - Timer restart on cycle, enable, writes, reset
// - Half-rate bit off keeps normal timer rate
// - Default mode USB100 source: 45 min limit
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ccc_core #(
  parameter int SEC_CYCLES = ccc_pkg::SEC_CYC,
  parameter int ALERT_CYCLES = ccc_pkg::ALERT_CYC,
  parameter int BLINK_CYCLES = ccc_pkg::BLINK_CYC
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic charge_enable_n_i,
  input wire logic vin_good_i,
  input wire logic usb100_i,
  input wire logic thermistor_input_a_fault_i,
  input wire logic thermistor_input_b_fault_i,
  input wire logic ts_in_window_i,
  input wire logic ts_cool_i,
  input wire logic ts_warm_i,
  input wire logic bat_lt_2v_i,
  input wire logic bat_lt_3v_i,
  input wire logic bat_lt_low_i,
  input wire logic bat_lt_rech_lo_i,
  input wire logic bat_lt_rech_hi_i,
  input wire logic ichg_lt_term_i,
  input wire logic ichg_lt_800_i,
  input wire logic input_power_regulation_i,
  input wire logic thermal_regulation_i,
  input wire logic sys_below_bat_i,
  input wire logic [12:0] ichg_ma_i,
  output logic [1:0] charge_phase_field_o,
  output logic [1:0] charge_fault_field_o,
  output logic [12:0] iset_ma_o,
  output logic [12:0] vreg_mv_o,
  output logic stat_o,
  output logic stat_oe_o,
  output logic alert_o,
  output logic battery_switch_on_o,
  output logic converter_on_o
);
  import ccc_pkg::*;

  ccc_core_s q;
  ccc_core_s s;
  logic chg, base_en, start_ok, susp, rech, term, go_fast, in_reg;
  logic wr, rd_stat, ev_alert, ev_fault, restart, conv, cool_cut;
  logic s_exp, u_exp, s_run, s_half, u_run;
  logic [16:0] s_lim;
  logic [12:0] pre_ma, fast_ma, vbase, vcap;
  logic [31:0] comp, clamp, rdv;

  // Safety timer: length depends on mode and battery level
  always_comb begin
    case (q.ctrl[B_DUR+:2])
      2'h0: s_lim = T_5H;
      2'h1: s_lim = T_8H;
      2'h2: s_lim = T_12H;
      default: s_lim = T_20H;
    endcase
    if (!q.ctrl[B_HOST]) s_lim = T_5H;
    if (bat_lt_low_i) s_lim = T_1H;
  end

  assign chg = (q.st == ST_PRE) || (q.st == ST_FAST);
  assign in_reg = input_power_regulation_i | thermal_regulation_i;
  assign s_run = chg & q.ctrl[B_TMR];
  assign s_half = in_reg & q.ctrl[B_HALF];
  assign u_run = chg & ~q.ctrl[B_HOST] & usb100_i;

  ccc_timer u_safety (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .tick_i(q.tick),
    .half_i(s_half),
    .run_i(s_run),
    .restart_i(q.restart),
    .limit_i(s_lim),
    .expire_o(s_exp)
  );

  ccc_timer u_usb (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .tick_i(q.tick),
    .half_i(1'b0),
    .run_i(u_run),
    .restart_i(q.restart),
    .limit_i(T_USB),
    .expire_o(u_exp)
  );

  // Whole next state; bus, sequencing and outputs in one pass
  always_comb begin
    s = q;
    s.restart = 1'b0;
    restart = 1'b0;
    ev_alert = 1'b0;
    ev_fault = 1'b0;
    rdv = '0;
    wr = q.dph & q.dwr & q.dmap;
    rd_stat = hsel_i & hready_i & htrans_i[1] & ~hwrite_i & (haddr_i == {28'h0, A_STAT});
    // Data phase of a register write
    if (wr) begin
      case (q.dadr)
        A_CTRL: begin
          s.ctrl = hwdata_i[15:0];
          s.ctrl[B_SRST] = 1'b0; // Self-clearing
          if (q.ctrl[B_CFG+:2] == CFG_OFF && hwdata_i[B_CFG+:2] == CFG_CHG) restart = 1'b1;
          if (!q.ctrl[B_TMR] && hwdata_i[B_TMR]) restart = 1'b1;
          if (hwdata_i[B_SRST]) begin
            s.ctrl = CTRL_RST;
            s.curr = CURR_RST;
            s.vreg = VREG_RST;
            restart = 1'b1;
          end
        end
        A_CURR: s.curr = hwdata_i[9:0];
        A_VREG: s.vreg = hwdata_i[11:0];
        default: ;
      endcase
    end
    // Enable pin high-low-high restarts the timer
    s.ce_prev = charge_enable_n_i;
    if (q.ce_prev && !charge_enable_n_i) s.ce_low = 1'b1;
    if (!q.ce_prev && charge_enable_n_i && q.ce_low) begin
      s.ce_low = 1'b0;
      restart = 1'b1;
    end
    // Start and hold conditions
    conv = vin_good_i & ~q.ctrl[B_HIZ];
    base_en = conv & (q.ctrl[B_CFG+:2] == CFG_CHG) & ~charge_enable_n_i & ~q.ctrl[B_FOFF] &
      ~q.tfault & ~s_exp & ~u_exp;
    susp = thermistor_input_a_fault_i | thermistor_input_b_fault_i | ~ts_in_window_i;
    start_ok = base_en & ~susp;
    rech = q.ctrl[B_RECH] ? bat_lt_rech_hi_i : bat_lt_rech_lo_i;
    term = q.ctrl[B_TERM] & ~in_reg & ichg_lt_term_i & ~rech;
    go_fast = ~bat_lt_3v_i;
    // Charge phase sequencing
    case (q.st)
      ST_IDLE: begin
        if (start_ok) begin
          s.st = go_fast ? ST_FAST : ST_PRE;
          restart = 1'b1;
        end
      end
      ST_PRE, ST_FAST: begin
        if (!base_en) begin
          s.st = ST_IDLE;
        end else if (susp) begin
          s.st = ST_SUSP;
        end else if (term) begin
          s.st = ST_DONE;
          ev_alert = 1'b1;
          ev_fault = 1'b1;
        end else begin
          s.st = go_fast ? ST_FAST : ST_PRE;
        end
      end
      ST_SUSP: begin
        if (!base_en) s.st = ST_IDLE;
        else if (!susp) s.st = go_fast ? ST_FAST : ST_PRE;
      end
      ST_DONE: begin
        if (!base_en) begin
          s.st = ST_IDLE;
        end else if (rech && !susp) begin
          s.st = go_fast ? ST_FAST : ST_PRE;
          restart = 1'b1;
        end
      end
      default: s.st = ST_IDLE;
    endcase
    // Timer restart clears the held fault; a same-cycle expiry still wins
    if (restart) s.tfault = 1'b0;
    if (s_exp) begin
      s.tfault = 1'b1;
      ev_alert = 1'b1;
      ev_fault = 1'b1;
      s.ctrl[B_HIZ] = ~q.ctrl[B_HOST];
    end
    if (u_exp) s.ctrl[B_HIZ] = 1'b1;
    s.restart = restart;
    if (ev_fault) s.fault = FLT_END;
    // Phase code
    case (s.st)
      ST_PRE: s.phase = PH_PRE;
      ST_FAST, ST_SUSP: s.phase = PH_FAST;
      ST_DONE: s.phase = PH_DONE;
      default: s.phase = PH_DIS;
    endcase
    // Address phase capture; zero wait states
    s.hrdyo = 1'b1;
    s.hresp = 1'b0;
    s.dph = hsel_i & hready_i & htrans_i[1];
    s.dwr = hwrite_i;
    s.dmap = (haddr_i[31:4] == 28'h0);
    s.dadr = {haddr_i[3:2], 2'h0};
    // Read data from the updated copy so a write just before is seen
    case (s.dadr)
      A_CTRL: rdv = {16'h0, s.ctrl};
      A_CURR: rdv = {22'h0, s.curr};
      A_VREG: rdv = {20'h0, s.vreg};
      default: rdv = {26'h0, s.tfault, s.ctrl[B_HIZ], s.fault, s.phase};
    endcase
    if (s.dph && !hwrite_i) s.hrdata = s.dmap ? rdv : 32'h0;
    // Reading status clears the fault field unless a new one arrives now
    if (rd_stat && !ev_fault) s.fault = 2'h0;
    // One-second tick for the timers
    s.tick = (q.pre == 27'(SEC_CYCLES - 1));
    s.pre = s.tick ? 27'h0 : q.pre + 27'h1;
    // Host alert pulse stretch
    if (ev_alert) s.acnt = 16'(ALERT_CYCLES);
    else if (q.acnt != 16'h0) s.acnt = q.acnt - 16'h1;
    s.alert = (s.acnt != 16'h0);
    // Free-running blink for the fault indication
    if (q.bcnt == 26'(BLINK_CYCLES - 1)) begin
      s.bcnt = 26'h0;
      s.blink = ~q.blink;
    end else begin
      s.bcnt = q.bcnt + 26'h1;
    end
    // Indicator pin: open drain, driven only while low
    if (s.st == ST_PRE || s.st == ST_FAST) s.stat = s.ctrl[B_EARLY] & ichg_lt_800_i;
    else if (s.st == ST_SUSP || s.tfault) s.stat = s.blink;
    else s.stat = 1'b1;
    s.stat_oe = ~s.stat;
    // Charge current set point
    pre_ma = 13'(PRE_BASE_MA + 32'(s.curr[F_PRE+:4]) * PRE_STEP_MA);
    fast_ma = 13'(FAST_BASE_MA + 32'(s.curr[F_FAST+:6]) * FAST_STEP_MA);
    cool_cut = (ts_cool_i & s.ctrl[B_COOL]) | s.ctrl[B_RED];
    if (s.st != ST_PRE && s.st != ST_FAST) s.iset = 13'h0;
    else if (bat_lt_2v_i) s.iset = 13'(MA_TRICKLE);
    else if (s.st == ST_PRE) s.iset = pre_ma;
    else s.iset = fast_ma;
    if (cool_cut) s.iset = 13'(s.iset / 13'(REDUCE_DIV));
    // Regulation voltage with warm cap and compensation
    vbase = 13'(VREG_BASE_MV + 32'(s.vreg[F_VREG+:6]) * VREG_STEP_MV);
    vcap = vbase;
    if (ts_warm_i) begin
      if (s.ctrl[B_WARM] && vbase > 13'(WARM_LO_MV)) vcap = 13'(WARM_LO_MV);
      else if (!s.ctrl[B_WARM] && vbase > 13'(WARM_HI_MV)) vcap = 13'(WARM_HI_MV);
    end
    comp = (32'(ichg_ma_i) * 32'(s.vreg[F_COMPR+:3]) * 32'(COMP_R_MOHM)) / 32'(COMP_DIV);
    clamp = 32'(s.vreg[F_CLAMP+:3]) * 32'(CLAMP_STEP_MV);
    s.vreg_mv = vcap + 13'((comp < clamp) ? comp : clamp);
    // Switch off once done; it returns only when the system droops
    s.bsw = ~s.ctrl[B_FOFF] & ((s.st == ST_PRE) | (s.st == ST_FAST) | (s.st == ST_SUSP) |
      sys_below_bat_i);
    s.conv = vin_good_i & ~s.ctrl[B_HIZ];
  end

  // State register; reset loads the power-on settings
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      q <= '0;
      q.ctrl <= CTRL_RST;
      q.curr <= CURR_RST;
      q.vreg <= VREG_RST;
      q.hrdyo <= 1'b1;
      q.stat <= 1'b1;
    end else begin
      q <= s;
    end
  end

  assign hrdata_o = q.hrdata;
  assign hreadyout_o = q.hrdyo;
  assign hresp_o = q.hresp;
  assign charge_phase_field_o = q.phase;
  assign charge_fault_field_o = q.fault;
  assign iset_ma_o = q.iset;
  assign vreg_mv_o = q.vreg_mv;
  assign stat_o = q.stat;
  assign stat_oe_o = q.stat_oe;
  assign alert_o = q.alert;
  assign battery_switch_on_o = q.bsw;
  assign converter_on_o = q.conv;

  // Checks on sequencing and outputs
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  a_start_gated: assert property (
    (chg && ($past(q.st) == ST_IDLE || $past(q.st) == ST_DONE)) |-> $past(start_ok))
    else $error("charge cycle began without start conditions");
  a_term_done: assert property (
    (chg && base_en && !susp && term) |=> (q.st == ST_DONE) && (charge_fault_field_o == FLT_END))
    else $error("termination did not complete the cycle");
  a_recharge_go: assert property (
    (q.st == ST_DONE && start_ok && rech) |=> chg)
    else $error("recharge did not start a new cycle");
  a_phase_fast: assert property (
    (q.st == ST_FAST) |-> (charge_phase_field_o == PH_FAST))
    else $error("fast phase code wrong");
  a_done_alert: assert property (
    $rose(q.st == ST_DONE) |-> alert_o ##1 alert_o)
    else $error("no alert pulse on completion");
  a_stat_charging: assert property (
    (chg && !q.ctrl[B_EARLY]) |-> (!stat_o && stat_oe_o))
    else $error("indicator not low while charging");
  a_window_susp: assert property (
    (chg && !ts_in_window_i) |=> !chg)
    else $error("charging continued outside the window");
  a_switch_done: assert property (
    (q.st == ST_DONE) |-> (!battery_switch_on_o || $past(sys_below_bat_i)))
    else $error("switch left on after termination");
  a_hiz_expire: assert property (
    (s_exp && !q.ctrl[B_HOST]) |=> (q.ctrl[B_HIZ] && q.tfault && !converter_on_o))
    else $error("default mode expiry did not suspend input");
  a_tfault_block: assert property (
    q.tfault |-> !chg)
    else $error("charging while timer fault held");

  c_done: cover property (q.st == ST_DONE);
  c_susp: cover property (q.st == ST_SUSP ##1 chg);
  c_tfault: cover property ($rose(q.tfault));
endmodule // ccc_core
`default_nettype wire

// ### sim/ccc_host_model.sv
// Host processor model: single word AHB-Lite master for the register bus.
// Assumes the slave's hreadyout is fed back as hready_i.
`timescale 1ns/1ps
`default_nettype none
module ccc_host_model (
  input wire logic clock_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i,
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output logic [31:0] hwdata_o
);
  import ccc_pkg::*;
  // Idle bus from time zero
  initial begin
    hsel_o = 1'b0;
    haddr_o = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o = 3'h2;
    hwdata_o = 32'h0;
  end
  // One transfer: address phase held until hready, then data phase until hready
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clock_i);
    hsel_o <= 1'b1;
    haddr_o <= a;
    hwrite_o <= wr;
    htrans_o <= 2'h2;
    @(posedge clock_i);
    while (hready_i !== 1'b1) @(posedge clock_i);
    hsel_o <= 1'b0;
    htrans_o <= 2'h0;
    hwdata_o <= d;
    @(posedge clock_i);
    while (hready_i !== 1'b1) @(posedge clock_i);
    q = hrdata_i;
    // Released lines flip so stale values cannot pass for fresh ones
    hwdata_o <= ~d;
    haddr_o <= ~a;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] unused;
    xfer(1'b1, a, d, unused);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask
  // Host ends a cycle itself by clearing the charge configuration field
  task automatic end_charge(input logic [31:0] ctrl);
    wr(32'(A_CTRL), ctrl & ~(32'h3 << B_CFG));
  endtask
endmodule // ccc_host_model
`default_nettype wire

// ### sim/charge_cycle_controller_tb.sv
// Self-checking bench of the charge cycle controller with a host bus model.
// Assumes shortened second, alert and blink counts set at the instance.
`timescale 1ns/1ps
`default_nettype none
module charge_cycle_controller_tb;
  import ccc_pkg::*;
  localparam int SEC = 2;
  localparam logic [31:0] CR = 32'(CTRL_RST);
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel, hwrite, hresp, stat, stat_oe, alert, bsw, conv;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0] htrans, phase, fault;
  logic [2:0] hsize;
  logic [12:0] iset, vmv;
  logic hready;
  logic en_n = 1'b0, vin = 1'b1, usb = 1'b0, tsa = 1'b0, tsb = 1'b0, win = 1'b1;
  logic cool = 1'b0, warm = 1'b0, lt2 = 1'b0, lt3 = 1'b0, low = 1'b0, rlo = 1'b0;
  logic rhi = 1'b0, lterm = 1'b0, l800 = 1'b0, ipr = 1'b0, thr = 1'b0, sysb = 1'b0;
  logic [12:0] ichg = 13'd1000;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  // Shortened counts keep the hour-long timers within the run
  ccc_core #(.SEC_CYCLES(SEC), .ALERT_CYCLES(4), .BLINK_CYCLES(3)) ccc_core_inst (
    .clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .charge_enable_n_i(en_n), .vin_good_i(vin), .usb100_i(usb),
    .thermistor_input_a_fault_i(tsa), .thermistor_input_b_fault_i(tsb),
    .ts_in_window_i(win), .ts_cool_i(cool), .ts_warm_i(warm), .bat_lt_2v_i(lt2),
    .bat_lt_3v_i(lt3), .bat_lt_low_i(low), .bat_lt_rech_lo_i(rlo),
    .bat_lt_rech_hi_i(rhi), .ichg_lt_term_i(lterm), .ichg_lt_800_i(l800),
    .input_power_regulation_i(ipr), .thermal_regulation_i(thr),
    .sys_below_bat_i(sysb), .ichg_ma_i(ichg), .charge_phase_field_o(phase),
    .charge_fault_field_o(fault), .iset_ma_o(iset), .vreg_mv_o(vmv), .stat_o(stat),
    .stat_oe_o(stat_oe), .alert_o(alert), .battery_switch_on_o(bsw),
    .converter_on_o(conv));
  ccc_host_model ccc_host_model_inst (
    .clock_i(clock_i), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
    .hwdata_o(hwdata));
  // 100 MHz clock
  always #5 clock_i = ~clock_i;
  task automatic complete_run();
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Hang guard, well above the three timer runs
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Sample just after the edge so its updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic wait_ph(input logic [1:0] ph, input int lim);
    int n;
    n = 0;
    while (phase !== ph && n < lim) begin
      tick(1);
      n++;
    end
  endtask
  task automatic t_reset();
    ccc_host_model_inst.rd(32'(A_CTRL), rdv);
    check(rdv, CR);
    ccc_host_model_inst.rd(32'(A_CURR), rdv);
    check(rdv, 32'h058);
    ccc_host_model_inst.rd(32'(A_VREG), rdv);
    check(rdv, 32'h02c);
    ccc_host_model_inst.rd(32'h40, rdv);
    check(rdv, 32'h0);
    tick(2);
    check(vmv, 4208);
    check(phase, PH_FAST);
    check(iset, 2048);
    check(stat, 1'b0);
    check(stat_oe, 1'b1);
    check(hresp, 1'b0);
  endtask
  task automatic t_start();
    logic [1:0] ph [3] = '{PH_PRE, PH_PRE, PH_FAST};
    int cur [3] = '{100, 256, 2048};
    // Enable pin, either thermistor fault, the B_FOFF bit or the window alone keeps a new cycle from starting
    for (int i = 0; i < 5; i++) begin
      ccc_host_model_inst.end_charge(CR);
      @(posedge clock_i);
      en_n <= (i == 0);
      tsa <= (i == 1);
      tsb <= (i == 2);
      win <= (i != 4);
      ccc_host_model_inst.wr(32'(A_CTRL), CR | (32'(i == 3) << B_FOFF));
      tick(3);
      check(phase, PH_DIS);
    end
    // Start current follows the battery voltage band
    for (int i = 0; i < 3; i++) begin
      ccc_host_model_inst.end_charge(CR);
      tick(2);
      check(phase, PH_DIS);
      check(stat, 1'b1);
      @(posedge clock_i);
      win <= 1'b1;
      lt2 <= (i == 0);
      lt3 <= (i < 2);
      ccc_host_model_inst.wr(32'(A_CTRL), CR);
      tick(2);
      check(phase, ph[i]);
      check(iset, cur[i]);
    end
  endtask
  task automatic t_comp();
    ccc_host_model_inst.wr(32'(A_VREG), 32'h02c | (32'h5 << F_COMPR) | (32'h2 << F_CLAMP));
    tick(2);
    check(vmv, 4272);
    @(posedge clock_i);
    ichg <= 13'd500;
    tick(3);
    check(vmv, 4258);
    ccc_host_model_inst.wr(32'(A_VREG), 32'h02c);
    @(posedge clock_i);
    warm <= 1'b1;
    for (int w = 0; w < 2; w++) begin
      ccc_host_model_inst.wr(32'(A_CTRL), CR | (32'(w) << B_WARM));
      tick(3);
      check(vmv, w ? 4050 : 4200);
    end
    @(posedge clock_i);
    warm <= 1'b0;
    cool <= 1'b1;
    ccc_host_model_inst.wr(32'(A_CTRL), CR | (32'h1 << B_COOL));
    tick(3);
    check(iset, 409);
    @(posedge clock_i);
    cool <= 1'b0;
    ccc_host_model_inst.wr(32'(A_CTRL), CR);
  endtask
  task automatic t_term();
    @(posedge clock_i);
    l800 <= 1'b1;
    ccc_host_model_inst.wr(32'(A_CTRL), CR | (32'h1 << B_EARLY));
    tick(2);
    check(stat, 1'b1);
    check(phase, PH_FAST);
    ccc_host_model_inst.wr(32'(A_CTRL), CR & ~(32'h1 << B_TERM));
    @(posedge clock_i);
    lterm <= 1'b1;
    tick(20);
    check(phase, PH_FAST);
    // Either regulation holds off termination
    for (int r = 0; r < 2; r++) begin
      @(posedge clock_i);
      ipr <= (r == 0);
      thr <= (r == 1);
      ccc_host_model_inst.wr(32'(A_CTRL), CR);
      tick(20);
      check(phase, PH_FAST);
    end
    @(posedge clock_i);
    thr <= 1'b0;
    wait_ph(PH_DONE, 10);
    check(phase, PH_DONE);
    check(alert, 1'b1);
    check(fault, FLT_END);
    check(bsw, 1'b0);
    check(conv, 1'b1);
    check(stat, 1'b1);
    tick(6);
    check(alert, 1'b0);
    ccc_host_model_inst.rd(32'(A_STAT), rdv);
    check(rdv[3:0], 4'hf);
    @(posedge clock_i);
    lterm <= 1'b0;
    l800 <= 1'b0;
    rlo <= 1'b1;
    wait_ph(PH_FAST, 10);
    check(phase, PH_FAST);
    check(stat, 1'b0);
    @(posedge clock_i);
    rlo <= 1'b0;
  endtask
  task automatic t_therm();
    int n;
    logic s;
    n = 0;
    s = stat;
    @(posedge clock_i);
    win <= 1'b0;
    for (int i = 0; i < 20; i++) begin
      tick(1);
      n += int'(stat !== s);
      s = stat;
    end
    check(n > 2, 1'b1);
    @(posedge clock_i);
    win <= 1'b1;
    tick(3);
    check(stat, 1'b0);
  endtask
  task automatic t_timer();
    int n;
    // Low battery gives the one-hour limit; the mode decides input suspend
    for (int m = 0; m < 2; m++) begin
      @(posedge clock_i);
      low <= 1'b1;
      ccc_host_model_inst.end_charge(CR | (32'(m) << B_HOST));
      ccc_host_model_inst.wr(32'(A_CTRL), CR | (32'(m) << B_HOST));
      n = 0;
      while (fault !== FLT_END && n < 8000) begin
        tick(1);
        n++;
      end
      check(n >= 3600 * SEC - 10 && n <= 3600 * SEC + 15, 1'b1);
      check(alert, 1'b1);
      tick(2);
      check(conv, 32'(m));
      ccc_host_model_inst.rd(32'(A_STAT), rdv);
      check(rdv[5], 1'b1);
    end
    @(posedge clock_i);
    low <= 1'b0;
    ccc_host_model_inst.end_charge(CR);
    ccc_host_model_inst.wr(32'(A_CTRL), CR);
    tick(2);
    ccc_host_model_inst.rd(32'(A_STAT), rdv);
    check(rdv[5], 1'b0);
    check(phase, PH_FAST);
  endtask
  task automatic t_usb();
    int n;
    @(posedge clock_i);
    usb <= 1'b1;
    ccc_host_model_inst.end_charge(CR);
    ccc_host_model_inst.wr(32'(A_CTRL), CR);
    n = 0;
    while (conv !== 1'b0 && n < 6000) begin
      tick(1);
      n++;
    end
    check(n >= 2700 * SEC - 20 && n <= 2700 * SEC + 20, 1'b1);
    ccc_host_model_inst.rd(32'(A_STAT), rdv);
    check(rdv[4], 1'b1);
  endtask
  // Main sequence after a 20-cycle reset
  initial begin
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    t_reset();
    t_start();
    t_comp();
    t_term();
    t_therm();
    t_timer();
    t_usb();
    complete_run();
  end
endmodule // charge_cycle_controller_tb
`default_nettype wire
